//--- design/pcsc_pkg.sv
// Contract
// - slot capability fields exist only in root port mode with a slot implemented
// - slot status kept inside the express capabilities register, not a separate structure; here it is its own word at OFS_SLOT_STS, OFS_EXP_CAP reads zero
// - power scale code 0..3 selects multiplier 1.0, 0.1, 0.01, 0.001
// - power scale reads zero before initialisation
// - write to slot power register makes port send a power limit message
// - slot power limit holds 0..255, times scale gives watts
// - slot number holds configured value 0..8191
// - l0s acceptable latency is read-only field of device capabilities
// - l0s acceptable latency defaults to the 64 ns code
// - l1 acceptable latency is read-only field of device capabilities
// - l1 acceptable latency defaults to the 1 us code
// - endpoint never enters l0s or l1 itself, only reports latencies
// - acceptable latency fields do not apply in root port mode
// - vendor capability exposes fixed read-only 16-bit user identifier
// - vendor capability exposes fixed read-only 4-bit revision
// - vendor capability exposes fixed read-only 16-bit board type identifier
`default_nettype none
package pcsc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_EXP_CAP = 12'h080;
	localparam logic [11:0] OFS_DEV_CAP = 12'h084;
	localparam logic [11:0] OFS_SLOT_CAP = 12'h094;
	localparam logic [11:0] OFS_SLOT_STS = 12'h098;
	localparam logic [11:0] OFS_VSEC_HDR = 12'h200;
	localparam logic [11:0] OFS_VSEC_ID = 12'h204;
	localparam logic [11:0] OFS_VSEC_BOARD = 12'h208;
	localparam logic [11:0] OFS_STATUS = 12'h20c;
	// device capabilities field positions
	localparam int DC_L0S_LSB = 6;
	localparam int DC_L1_LSB = 9;
	// slot capabilities field positions
	localparam int SC_LIMIT_LSB = 7;
	localparam int SC_SCALE_LSB = 15;
	localparam int SC_NUM_LSB = 19;
	localparam int VH_REV_LSB = 16;
	localparam int ST_SLOT_EN = 0;
	localparam int ST_L0S = 1;
	localparam int ST_L1 = 2;
	localparam logic [2:0] LAT_L0S_64NS = 3'h0;
	localparam logic [2:0] LAT_L1_1US = 3'h0;
	localparam logic [2:0] LAT_NO_LIMIT = 3'h7;
	localparam logic [1:0] SCALE_RESET = 2'h0;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam int MSG_PULSE_NS = 16;
	localparam int CLK_NS = 8;
	localparam int MSG_CYC = (MSG_PULSE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [1:0] {
		PCSC_SCALE_1X = 2'b00,
		PCSC_SCALE_0P1X = 2'b01,
		PCSC_SCALE_0P01X = 2'b10,
		PCSC_SCALE_0P001X = 2'b11
	} pcsc_scale_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pcsc_req_t;
	typedef struct packed {
		logic [1:0] scale;
		logic [7:0] limit;
	} pcsc_power_t;
endpackage
`default_nettype wire

//--- design/pcsc_msg_pulse.sv
`default_nettype none
module pcsc_msg_pulse
	import pcsc_pkg::*;
#(
	parameter int LEN = MSG_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic trig,
	output logic busy
);
	typedef enum logic [1:0] {
		PCSC_IDLE = 2'b00,
		PCSC_SEND = 2'b01
	} pcsc_mstate_t;
	pcsc_mstate_t state;
	logic [7:0] cnt;
	// a trigger during a send restarts the busy window
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= PCSC_IDLE;
			cnt <= 8'h00;
		end else begin
			case (state)
				PCSC_IDLE: begin
					if (trig) begin
						state <= PCSC_SEND;
						cnt <= 8'(LEN - 1);
					end
				end
				PCSC_SEND: begin
					if (trig) begin
						cnt <= 8'(LEN - 1);
					end else if (cnt == 8'h00) begin
						state <= PCSC_IDLE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				default: state <= PCSC_IDLE;
			endcase
		end
	end
	assign busy = (state == PCSC_SEND);
endmodule
`default_nettype wire

//--- design/pcsc_cap_fields.sv
// The plain strobed port is this design's own decision.
`default_nettype none
module pcsc_cap_fields
	import pcsc_pkg::*;
#(
	parameter bit ROOT_PORT = 1'b0,
	parameter bit SLOT_IMPL = 1'b0,
	parameter logic [7:0] SLOT_LIMIT = 8'h00,
	parameter logic [12:0] SLOT_NUMBER = 13'h0000,
	parameter logic [2:0] L0S_LAT = LAT_L0S_64NS,
	parameter logic [2:0] L1_LAT = LAT_L1_1US,
	// identification values below are arbitrary
	parameter logic [15:0] VSEC_VENDOR_EXT_USER_IDENTIFIER = 16'h0abc,
	parameter logic [3:0] VSEC_REV = 4'h1,
	parameter logic [15:0] VSEC_BOARD_ID = 16'h0123
) (
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RSTN,
	// register port
	input wire logic [11:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [31:0] O_RDATA,
	// slot power message
	output logic O_PWR_MSG,
	output logic [9:0] O_PWR_VAL
);
	pcsc_req_t req;
	pcsc_power_t pwr;
	logic slot_en;
	logic lat_en;
	logic scale_wr;
	logic msg_busy;
	logic [31:0] next_rdata;
	logic [31:0] dev_cap;
	logic [31:0] slot_cap;
	logic wr_seen;
	logic msg_start;

	assign req = '{wr: I_WR, rd: I_RD, addr: I_ADDR, wdata: I_WDATA};

	// slot fields only in root port with slot
	assign slot_en = ROOT_PORT && SLOT_IMPL;
	// latency fields dropped in root port mode
	assign lat_en = !ROOT_PORT;
	// write to slot capability register triggers message
	assign scale_wr = req.wr && (req.addr == OFS_SLOT_CAP) && slot_en;

	// scale code kept as written, the only writable slot field
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pwr.scale <= SCALE_RESET;
			pwr.limit <= 8'h00;
		end else if (scale_wr) begin
			pwr.scale <= I_WDATA[SC_SCALE_LSB +: 2];
			// limit fixed by build, reloaded with every write
			pwr.limit <= SLOT_LIMIT;
		end
	end

	pcsc_msg_pulse #(
		.LEN(MSG_CYC)
	) u_msg (
		.clk(I_CLK),
		.rstn(I_RSTN),
		.trig(scale_wr),
		.busy(msg_busy)
	);

	// one message per accepted write
	// a rewrite during a send still reaches the link, so no scale is lost
	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			wr_seen <= 1'b0;
		end else begin
			wr_seen <= scale_wr;
		end
	end
	assign msg_start = wr_seen;

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_PWR_MSG <= 1'b0;
			O_PWR_VAL <= 10'h000;
		end else begin
			O_PWR_MSG <= msg_start;
			if (msg_start) begin
				O_PWR_VAL <= {pwr.scale, pwr.limit};
			end
		end
	end

	// l0s and l1 latency fields, read only
	always_comb begin
		dev_cap = RD_ZERO;
		if (lat_en) begin
			dev_cap[DC_L0S_LSB +: 3] = L0S_LAT;
			dev_cap[DC_L1_LSB +: 3] = L1_LAT;
		end
	end

	// slot number and limit in slot capability word
	always_comb begin
		slot_cap = RD_ZERO;
		if (slot_en) begin
			slot_cap[SC_LIMIT_LSB +: 8] = SLOT_LIMIT;
			slot_cap[SC_SCALE_LSB +: 2] = pwr.scale;
			slot_cap[SC_NUM_LSB +: 13] = SLOT_NUMBER;
		end
	end

	// reads return constants except the slot scale and slot status busy bit, writes have no other effect
	always_comb begin
		next_rdata = RD_ZERO;
		case (req.addr)
			OFS_EXP_CAP: next_rdata = RD_ZERO;
			OFS_DEV_CAP: next_rdata = dev_cap;
			OFS_SLOT_CAP: next_rdata = slot_cap;
			// slot status word within express capability area
			OFS_SLOT_STS: next_rdata = {31'h0, msg_busy && slot_en};
			OFS_VSEC_HDR: next_rdata = {12'h000, VSEC_REV, 16'h0000};
			OFS_VSEC_ID: next_rdata = {16'h0000, VSEC_VENDOR_EXT_USER_IDENTIFIER};
			OFS_VSEC_BOARD: next_rdata = {16'h0000, VSEC_BOARD_ID};
			// no link power state, only reports enables
			OFS_STATUS: next_rdata = {29'h0, lat_en, lat_en, slot_en};
			default: next_rdata = RD_ZERO;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			O_RDATA <= RD_ZERO;
		end else if (req.rd) begin
			O_RDATA <= next_rdata;
		end else begin
			O_RDATA <= RD_ZERO;
		end
	end

	a_scale_reset: assert property (@(posedge I_CLK) $rose(I_RSTN) |-> pwr.scale == SCALE_RESET)
		else $error("scale not zero after reset");
	// write brings a message two cycles later
	a_msg_after_wr: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		scale_wr && !msg_busy |-> ##2 O_PWR_MSG)
		else $error("no power message after write");
	a_devcap_read: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_DEV_CAP |=> O_RDATA == dev_cap)
		else $error("device capability read wrong");
	a_l0s_field: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_DEV_CAP && lat_en |=> O_RDATA[DC_L0S_LSB +: 3] == L0S_LAT)
		else $error("l0s field wrong");
	a_l1_field: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_DEV_CAP && lat_en |=> O_RDATA[DC_L1_LSB +: 3] == L1_LAT)
		else $error("l1 field wrong");
	a_vendor_ext_user_identifier: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_VSEC_ID |=> O_RDATA[15:0] == VSEC_VENDOR_EXT_USER_IDENTIFIER)
		else $error("vendor_ext_user_identifier wrong");
	a_vsec_rev: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_VSEC_HDR |=> O_RDATA[VH_REV_LSB +: 4] == VSEC_REV)
		else $error("revision wrong");
	a_board_id: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_VSEC_BOARD |=> O_RDATA[15:0] == VSEC_BOARD_ID)
		else $error("board id wrong");
	a_slot_gate: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_SLOT_CAP && !slot_en |=> O_RDATA == RD_ZERO)
		else $error("slot fields visible without slot");

	// steps of a slot power write, its message and a slot capability read
	sequence s_scale_write;
		scale_wr;
	endsequence

	sequence s_msg_out;
		##2 (O_PWR_MSG && O_PWR_VAL[7:0] == SLOT_LIMIT);
	endsequence

	sequence s_read_slot;
		req.rd && req.addr == OFS_SLOT_CAP && slot_en;
	endsequence

	a_msg_value: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_scale_write |-> s_msg_out)
		else $error("message missing or limit wrong");

	a_msg_scale: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		scale_wr |-> ##2 O_PWR_VAL[9:8] == $past(I_WDATA[SC_SCALE_LSB +: 2], 2))
		else $error("message scale wrong");

	a_msg_source: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		O_PWR_MSG |-> $past(scale_wr, 2))
		else $error("message without write");

	a_no_slot_msg: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!slot_en |-> !O_PWR_MSG)
		else $error("message without slot");

	// scale stays at reset value without slot
	a_scale_no_slot: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!slot_en |-> pwr.scale == SCALE_RESET)
		else $error("scale moved without slot");

	// scale only moves on a slot write
	a_scale_hold: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!scale_wr |=> $stable(pwr.scale))
		else $error("scale changed without write");

	a_scale_code: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		scale_wr |=> pwr.scale == $past(I_WDATA[SC_SCALE_LSB +: 2]))
		else $error("scale code not taken");

	a_slot_number: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_read_slot |=> O_RDATA[SC_NUM_LSB +: 13] == SLOT_NUMBER)
		else $error("slot number wrong");

	a_slot_limit: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_read_slot |=> O_RDATA[SC_LIMIT_LSB +: 8] == SLOT_LIMIT)
		else $error("slot limit wrong");

	// scale as it stood at the read
	a_slot_scale: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		s_read_slot |=> O_RDATA[SC_SCALE_LSB +: 2] == $past(pwr.scale))
		else $error("slot scale wrong");

	// latency fields hidden in root port
	a_root_lat_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_DEV_CAP && !lat_en |=> O_RDATA == RD_ZERO)
		else $error("latency visible in root port");

	a_status_word: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_STATUS |=>
		O_RDATA == {29'h0, !ROOT_PORT, !ROOT_PORT, ROOT_PORT && SLOT_IMPL})
		else $error("status word wrong");

	// slot status bit follows the sender
	a_slot_status: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_SLOT_STS |=> O_RDATA[0] == $past(msg_busy && slot_en))
		else $error("slot status wrong");

	// read data only after a read strobe
	a_rdata_idle: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		!req.rd |=> O_RDATA == RD_ZERO)
		else $error("read data outside read cycle");

	a_exp_cap_zero: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_EXP_CAP |=> O_RDATA == RD_ZERO)
		else $error("express capability word not zero");

	// upper half of user identifier word empty
	a_vendor_ext_user_identifier_rest: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_VSEC_ID |=> O_RDATA[31:16] == 16'h0000)
		else $error("vendor_ext_user_identifier word upper half not zero");

	// upper half of board word empty
	a_board_rest: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
		req.rd && req.addr == OFS_VSEC_BOARD |=> O_RDATA[31:16] == 16'h0000)
		else $error("board word upper half not zero");
endmodule
`default_nettype wire

//--- verification/pcsc_link_model.sv
`default_nettype none
module pcsc_link_model (
	// link side
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_msg,
	input wire logic [9:0] i_val,
	// observed messages
	output logic [7:0] o_count,
	output logic [9:0] o_val
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_count <= 8'h00;
			o_val <= 10'h000;
		end else if (i_msg) begin
			o_count <= o_count + 8'h01;
			o_val <= i_val;
		end
	end
endmodule
`default_nettype wire

//--- verification/pcie_slot_pm_vsec_capability_fields_tb.sv
`default_nettype none
module pcie_slot_pm_vsec_capability_fields_tb;
	import pcsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] LIM = 8'h5a;
	localparam logic [12:0] NUM = 13'h1abc;
	// identification values are arbitrary
	localparam logic [15:0] UID = 16'h3c5a;
	localparam logic [3:0] REV = 4'h9;
	localparam logic [15:0] BID = 16'h7e21;
	localparam logic [2:0] L1E = LAT_L1_1US;
	localparam logic [31:0] SLOT = {NUM, 4'h0, LIM, 7'h00};
	logic clk, rstn, wr, rd, msg_r, msg_e;
	logic [11:0] addr;
	logic [31:0] wdata, rd_r, rd_e, seed, r;
	logic [9:0] val_r, val_e, lv_r, lv_e;
	logic [7:0] cnt_r, cnt_e, c0;
	int failures = 0;
	int check_count = 0;
	pcsc_cap_fields #(.ROOT_PORT(1'b1), .SLOT_IMPL(1'b1), .SLOT_LIMIT(LIM), .SLOT_NUMBER(NUM),
		.VSEC_VENDOR_EXT_USER_IDENTIFIER(UID), .VSEC_REV(REV), .VSEC_BOARD_ID(BID)) dut_u (.I_CLK(clk),
		.I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rd_r),
		.O_PWR_MSG(msg_r), .O_PWR_VAL(val_r));
	pcsc_cap_fields #(.L1_LAT(L1E), .VSEC_VENDOR_EXT_USER_IDENTIFIER(UID), .VSEC_REV(REV), .VSEC_BOARD_ID(BID))
		dut_ep (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rd_e), .O_PWR_MSG(msg_e), .O_PWR_VAL(val_e));
	pcsc_link_model lnk_r (.i_clk(clk), .i_rstn(rstn), .i_msg(msg_r), .i_val(val_r),
		.o_count(cnt_r), .o_val(lv_r));
	pcsc_link_model lnk_e (.i_clk(clk), .i_rstn(rstn), .i_msg(msg_e), .i_val(val_e),
		.o_count(cnt_e), .o_val(lv_e));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr1(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd1(input logic [11:0] a, input logic [31:0] er, input logic [31:0] ee,
		input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("rdata_root", er, rd_r & m);
		chk("rdata_ep", ee, rd_e & m);
	endtask
	// write with scale in bits 16:15, rest random; message two edges on
	task automatic pwr(input logic [1:0] s);
		c0 = cnt_r;
		wr1(OFS_SLOT_CAP, (xs() & 32'hfffe7fff) | {15'h0000, s, 15'h0000});
		@(posedge clk);
		#1;
		chk("pwr_msg", 32'h1, {31'h0, msg_r});
		chk("pwr_val", {22'h0, s, LIM}, {22'h0, val_r});
		@(posedge clk);
		#1;
		chk("pwr_msg_end", 32'h0, {31'h0, msg_r});
		chk("pwr_count", {24'h0, c0 + 8'h01}, {24'h0, cnt_r});
	endtask
	task automatic finish_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'h000;
		wdata = 32'h0;
		seed = 32'h4f;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd1(OFS_SLOT_CAP, SLOT, RD_ZERO, 32'hfff9ff80);
		rd1(OFS_DEV_CAP, RD_ZERO, {20'h0, L1E, LAT_L0S_64NS, 6'h0}, 32'hfc0);
		rd1(OFS_VSEC_HDR, {12'h0, REV, 16'h0}, {12'h0, REV, 16'h0}, 32'hf0000);
		rd1(OFS_VSEC_ID, {16'h0, UID}, {16'h0, UID}, 32'hffff);
		rd1(OFS_VSEC_BOARD, {16'h0, BID}, {16'h0, BID}, 32'hffff);
		rd1(OFS_STATUS, 32'h1, 32'h6, 32'h7);
		rd1(OFS_SLOT_STS, RD_ZERO, RD_ZERO, 32'hffffffff);
		rd1(OFS_EXP_CAP, RD_ZERO, RD_ZERO, 32'hffffffff);
		rd1(12'h3f0, RD_ZERO, RD_ZERO, 32'hffffffff);
		@(posedge clk);
		#1;
		chk("rdata_idle", RD_ZERO, rd_r);
		wr1(OFS_DEV_CAP, 32'hffffffff);
		rd1(OFS_DEV_CAP, RD_ZERO, {20'h0, L1E, 9'h0}, 32'hfc0);
		for (int i = 0; i < 8; i++) begin
			r = xs();
			pwr(i < 4 ? 2'(i) : r[1:0]);
		end
		rd1(OFS_SLOT_CAP, SLOT, RD_ZERO, 32'hfff87f80);
		// back-to-back writes: one message each, the last carries the last scale
		c0 = cnt_r;
		@(posedge clk);
		addr <= OFS_SLOT_CAP;
		wdata <= 32'h00008000;
		wr <= 1'b1;
		@(posedge clk);
		wdata <= 32'h00010000;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		addr <= OFS_SLOT_STS;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("sts_busy", 32'h1, rd_r);
		repeat (3) @(posedge clk);
		#1;
		chk("b2b_count", {24'h0, c0 + 8'h02}, {24'h0, cnt_r});
		chk("b2b_val", {22'h0, 2'h2, LIM}, {22'h0, lv_r});
		chk("ep_msgs", RD_ZERO, {24'h0, cnt_e});
		finish_test();
	end
endmodule
`default_nettype wire
